// ==== rdio_pkg.sv ====
// Purpose: shared constants and types of the dedicated parallel i/o handler
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes:   field configuration packs four 5-bit bit indices
package rdio_pkg;
    ////////////////////////////////////////////////////////////////////////////
    localparam logic [11:0] OFS_CTRL       = 12'h000;
    localparam logic [11:0] OFS_FIELD_CFG  = 12'h004;
    localparam logic [11:0] OFS_SLOT_RUN   = 12'h008;
    localparam logic [11:0] OFS_LINE_NUM   = 12'h00c;
    localparam logic [11:0] OFS_ERROR_NUM  = 12'h010;
    localparam logic [11:0] OFS_PROGRAM    = 12'h014;
    localparam logic [11:0] OFS_OVERRIDE   = 12'h018;
    localparam logic [11:0] OFS_HAND_OUT   = 12'h01c;
    localparam logic [11:0] OFS_STATUS     = 12'h020;
    localparam logic [11:0] OFS_WAIT       = 12'h024;
    localparam logic [11:0] OFS_HAND_IN    = 12'h028;

    localparam int CTRL_JOG_CLEAR_BIT      = 0;
    localparam int CFG_IN_START_LSB        = 0;
    localparam int CFG_IN_END_LSB          = 5;
    localparam int CFG_OUT_START_LSB       = 10;
    localparam int CFG_OUT_END_LSB         = 15;
    localparam int IDX_W                   = 5;
    localparam int STS_JOG_VALID_BIT       = 0;
    localparam int STS_JOG_MODE_LSB        = 1;
    localparam int STS_IND_LSB             = 3;
    localparam int STS_HAND_FAULT_LSB      = 8;

    localparam logic [19:0] RST_FIELD_CFG  = 20'h380e0;
    localparam logic [31:0] RST_OVERRIDE   = 32'h00000064;
    localparam logic [31:0] RST_WORD       = 32'h00000000;

    typedef enum logic [2:0] {
        RO_NONE,
        RO_PROGRAM,
        RO_LINE,
        RO_OVERRIDE,
        RO_ERROR
    } rdio_readout_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } rdio_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } rdio_apb_rsp_type;

    typedef struct packed {
        rdio_readout_type sel;
        logic             prg_q;
        logic             ovs_q;
        logic [3:0]       req_q;
        logic             jog_en_q;
        logic             jog_valid;
        logic [1:0]       jog_mode;
        logic [7:0]       jog_pos;
        logic [7:0]       jog_neg;
        logic [31:0]      slot_wait;
        logic [31:0]      slot_run;
        logic [31:0]      program_number;
        logic [31:0]      override_value;
        logic [31:0]      line_number;
        logic [31:0]      error_number;
        logic [31:0]      numeric_out;
        logic [19:0]      field_cfg;
        logic [23:0]      hand_out;
        logic [23:0]      hand_in;
        logic [2:0]       hand_fault;
        logic [31:0]      prdata;
        logic             pslverr;
    } rdio_state_type;
endpackage

// ==== rdio_handler.sv ====
// Purpose: dedicated parallel i/o handshake logic of a robot controller
// Assumes: all pins synchronous to mclk; apb master per protocol
// Notes:
// Notes on behaviour
// [RQ1] level inputs act only while asserted
// [RQ2] edge inputs act on rise, hold afterwards
// [RQ3] numeric fields set by four bit indices
// [RQ4] slot pause input gives matching wait output
// [RQ5] program select rise captures numeric input
// [RQ6] override select rise captures numeric input; an apb write to the override register in the same cycle wins instead
// [RQ7] sequencer holds numeric input during selection
// [RQ8] numeric output shows the active readout
// [RQ9] program request shows program, raises indicator
// [RQ10] line request shows line, raises indicator
// [RQ11] override request shows override, raises indicator
// [RQ12] error request shows error, raises indicator
// [RQ13] jog enable rise sets jog valid
// [RQ14] jog mode in, current mode out
// [RQ15] positive jog per axis while asserted
// [RQ16] negative jog per axis while asserted
// [RQ17] hand output bits mirrored per mechanism
// [RQ18] hand input bits mirrored per mechanism
// [RQ19] hand fault input mirrored to fault output
// [RQ20] at most one readout indicator at once
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module rdio_handler #(
    parameter int SLOTS = 32,
    parameter int AXES  = 8
) (
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    input  wire rdio_pkg::rdio_apb_req_type apb_req,
    output var  rdio_pkg::rdio_apb_rsp_type apb_rsp,
    input  wire logic [31:0]               slot_pause_in,
    output logic      [31:0]               slot_wait_out,
    input  wire logic                      program_select_in,
    input  wire logic                      override_select_in,
    input  wire logic [31:0]               numeric_value_field,
    output logic      [31:0]               numeric_value_out,
    input  wire logic                      program_number_readout_req,
    input  wire logic                      line_number_readout_req,
    input  wire logic                      override_readout_req,
    input  wire logic                      error_number_readout_req,
    output logic                           program_readout_active,
    output logic                           line_readout_active,
    output logic                           override_readout_active,
    output logic                           error_readout_active,
    input  wire logic                      external_jog_enable,
    output logic                           jog_valid_out,
    input  wire logic [1:0]                jog_mode_select,
    output logic      [1:0]                jog_mode_out,
    input  wire logic [7:0]                jog_pos_req,
    input  wire logic [7:0]                jog_neg_req,
    output logic      [7:0]                axis_jog_pos,
    output logic      [7:0]                axis_jog_neg,
    output logic      [23:0]               hand_output_status_group,
    input  wire logic [23:0]               hand_input_pins,
    output logic      [23:0]               hand_input_status_group,
    input  wire logic [2:0]                hand_fault_signal,
    output logic      [2:0]                hand_fault_out
);
    ////////////////////////////////////////////////////////////////////////////
    // the state word carries fixed 32-slot and 8-axis lanes
    if (SLOTS < 1 || SLOTS > 32) begin : g_chk_slots
        $error("SLOTS must lie in 1..32");
    end
    if (AXES < 1 || AXES > 8) begin : g_chk_axes
        $error("AXES must lie in 1..8");
    end

    localparam logic [31:0] SLOT_MASK = 32'(64'hffffffff >> (32 - SLOTS));
    localparam logic [7:0]  AXIS_MASK = 8'(16'h00ff >> (8 - AXES));

    // bit-field extraction and placement; an end below start yields no field
    function automatic logic [31:0] field_mask(input logic [4:0] s, input logic [4:0] e);
        logic [63:0] m;
        m = 64'h0;
        if (e >= s) begin
            m = ~(64'hffffffffffffffff << (6'(e) - 6'(s) + 6'd1));
        end
        return m[31:0];
    endfunction

    function automatic logic [31:0] field_get(input logic [31:0] w, input logic [4:0] s,
                                              input logic [4:0] e);
        return (w >> s) & field_mask(s, e);
    endfunction

    function automatic logic [31:0] field_put(input logic [31:0] v, input logic [4:0] s,
                                              input logic [4:0] e);
        return (v & field_mask(s, e)) << s;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    rdio_pkg::rdio_state_type r;
    rdio_pkg::rdio_state_type next_r;

    logic [4:0]  in_start;
    logic [4:0]  in_end;
    logic [4:0]  out_start;
    logic [4:0]  out_end;
    logic [31:0] in_value;
    logic [3:0]  req_now;
    logic [3:0]  req_rise;
    logic        wr_acc;
    logic        rd_setup;

    assign in_start  = r.field_cfg[rdio_pkg::CFG_IN_START_LSB +: rdio_pkg::IDX_W];  // [RQ3]
    assign in_end    = r.field_cfg[rdio_pkg::CFG_IN_END_LSB +: rdio_pkg::IDX_W];
    assign out_start = r.field_cfg[rdio_pkg::CFG_OUT_START_LSB +: rdio_pkg::IDX_W];
    assign out_end   = r.field_cfg[rdio_pkg::CFG_OUT_END_LSB +: rdio_pkg::IDX_W];
    // the sequencer is trusted to hold the field steady around the select edge
    assign in_value  = field_get(numeric_value_field, in_start, in_end);  // [RQ7]
    assign req_now   = {error_number_readout_req, override_readout_req,
                        line_number_readout_req, program_number_readout_req};
    assign req_rise  = req_now & ~r.req_q;
    assign wr_acc    = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd_setup  = apb_req.psel & ~apb_req.penable;

    always_comb begin
        next_r = r;
        // edge-type inputs: only the rise acts, a fall leaves the state alone
        next_r.prg_q    = program_select_in;
        next_r.ovs_q    = override_select_in;
        next_r.req_q    = req_now;
        next_r.jog_en_q = external_jog_enable;
        if (program_select_in && !r.prg_q) begin
            next_r.program_number = in_value;  // [RQ5] [RQ2]
        end
        if (override_select_in && !r.ovs_q) begin
            next_r.override_value = in_value;  // [RQ6] [RQ2]
        end
        // newest request takes the shared field; ties resolved by fixed priority
        if (req_rise[0]) begin
            next_r.sel = rdio_pkg::RO_PROGRAM;  // [RQ9] [RQ20]
        end else if (req_rise[1]) begin
            next_r.sel = rdio_pkg::RO_LINE;  // [RQ10] [RQ20]
        end else if (req_rise[2]) begin
            next_r.sel = rdio_pkg::RO_OVERRIDE;  // [RQ11] [RQ20]
        end else if (req_rise[3]) begin
            next_r.sel = rdio_pkg::RO_ERROR;  // [RQ12] [RQ20]
        end
        unique case (next_r.sel)
            rdio_pkg::RO_PROGRAM:  next_r.numeric_out = field_put(r.program_number,
                                                                  out_start, out_end);  // [RQ8]
            rdio_pkg::RO_LINE:     next_r.numeric_out = field_put(r.line_number,
                                                                  out_start, out_end);  // [RQ8]
            rdio_pkg::RO_OVERRIDE: next_r.numeric_out = field_put(r.override_value,
                                                                  out_start, out_end);  // [RQ8]
            rdio_pkg::RO_ERROR:    next_r.numeric_out = field_put(r.error_number,
                                                                  out_start, out_end);  // [RQ8]
            default:               next_r.numeric_out = rdio_pkg::RST_WORD;
        endcase
        // level-type inputs are sampled every cycle; slot pause is gated by slot_run, jog requests by jog_valid
        next_r.slot_wait  = slot_pause_in & r.slot_run & SLOT_MASK;  // [RQ4] [RQ1]
        next_r.jog_mode   = jog_mode_select;  // [RQ14] [RQ1]
        next_r.jog_pos    = r.jog_valid ? (jog_pos_req & AXIS_MASK) : 8'h00;  // [RQ15] [RQ1]
        next_r.jog_neg    = r.jog_valid ? (jog_neg_req & AXIS_MASK) : 8'h00;  // [RQ16] [RQ1]
        next_r.hand_in    = hand_input_pins;  // [RQ18]
        next_r.hand_fault = hand_fault_signal;  // [RQ19] [RQ1]
        // apb writes, taken in the access phase
        if (wr_acc) begin
            unique case (apb_req.paddr)
                rdio_pkg::OFS_CTRL: begin
                    if (apb_req.pwdata[rdio_pkg::CTRL_JOG_CLEAR_BIT]) begin
                        next_r.jog_valid = 1'b0;
                    end
                end
                rdio_pkg::OFS_FIELD_CFG: next_r.field_cfg      = apb_req.pwdata[19:0];
                rdio_pkg::OFS_SLOT_RUN:  next_r.slot_run       = apb_req.pwdata & SLOT_MASK;
                rdio_pkg::OFS_LINE_NUM:  next_r.line_number    = apb_req.pwdata;
                rdio_pkg::OFS_ERROR_NUM: next_r.error_number   = apb_req.pwdata;
                rdio_pkg::OFS_OVERRIDE:  next_r.override_value = apb_req.pwdata;
                rdio_pkg::OFS_HAND_OUT:  next_r.hand_out       = apb_req.pwdata[23:0];  // [RQ17]
                default: ;
            endcase
        end
        // a jog enable rise beats a clear in the same cycle
        if (external_jog_enable && !r.jog_en_q) begin
            next_r.jog_valid = 1'b1;  // [RQ13] [RQ2]
        end
        // read data and error fetched in setup so both come from flops
        next_r.pslverr = 1'b0;
        if (rd_setup) begin
            next_r.prdata = rdio_pkg::RST_WORD;
            unique case (apb_req.paddr)
                rdio_pkg::OFS_CTRL:      next_r.prdata = rdio_pkg::RST_WORD;
                rdio_pkg::OFS_FIELD_CFG: next_r.prdata = {12'h000, r.field_cfg};
                rdio_pkg::OFS_SLOT_RUN:  next_r.prdata = r.slot_run;
                rdio_pkg::OFS_LINE_NUM:  next_r.prdata = r.line_number;
                rdio_pkg::OFS_ERROR_NUM: next_r.prdata = r.error_number;
                rdio_pkg::OFS_PROGRAM:   next_r.prdata = r.program_number;
                rdio_pkg::OFS_OVERRIDE:  next_r.prdata = r.override_value;
                rdio_pkg::OFS_HAND_OUT:  next_r.prdata = {8'h00, r.hand_out};
                rdio_pkg::OFS_STATUS:    next_r.prdata = {21'h000000, r.hand_fault, 1'b0,
                                                          req_ind(r.sel), r.jog_mode,
                                                          r.jog_valid};
                rdio_pkg::OFS_WAIT:      next_r.prdata = r.slot_wait;
                rdio_pkg::OFS_HAND_IN:   next_r.prdata = {8'h00, r.hand_in};
                default:                 next_r.pslverr = 1'b1;
            endcase
        end else if (apb_req.psel) begin
            next_r.pslverr = r.pslverr;
        end
    end

    function automatic logic [3:0] req_ind(input rdio_pkg::rdio_readout_type s);
        return {s == rdio_pkg::RO_ERROR, s == rdio_pkg::RO_OVERRIDE,
                s == rdio_pkg::RO_LINE, s == rdio_pkg::RO_PROGRAM};
    endfunction

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r                <= '0;
            r.sel            <= rdio_pkg::RO_NONE;
            r.field_cfg      <= rdio_pkg::RST_FIELD_CFG;
            r.override_value <= rdio_pkg::RST_OVERRIDE;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // zero-wait slave: every access phase completes at once
    assign apb_rsp.pready            = 1'b1;
    assign apb_rsp.prdata            = r.prdata;
    assign apb_rsp.pslverr           = apb_req.psel & apb_req.penable & r.pslverr;
    assign slot_wait_out             = r.slot_wait;
    assign numeric_value_out         = r.numeric_out;
    assign {error_readout_active, override_readout_active,
            line_readout_active, program_readout_active} = req_ind(r.sel);  // [RQ20]
    assign jog_valid_out             = r.jog_valid;
    assign jog_mode_out              = r.jog_mode;
    assign axis_jog_pos              = r.jog_pos;
    assign axis_jog_neg              = r.jog_neg;
    assign hand_output_status_group  = r.hand_out;  // [RQ17]
    assign hand_input_status_group   = r.hand_in;  // [RQ18]
    assign hand_fault_out            = r.hand_fault;  // [RQ19]

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_program_capture;
        $rose(program_select_in) |=> r.program_number == $past(in_value);
    endproperty
    a_program_capture: assert property (p_program_capture)  // [RQ5]
        else $error("program number not captured on select rise");

    property p_override_capture;
        $rose(override_select_in) && !(wr_acc && apb_req.paddr == rdio_pkg::OFS_OVERRIDE)
            |=> r.override_value == $past(in_value);
    endproperty
    a_override_capture: assert property (p_override_capture)  // [RQ6]
        else $error("override not captured on select rise");

    property p_program_readout;
        $rose(program_number_readout_req) |=> program_readout_active
            ##1 numeric_value_out == field_put($past(r.program_number), out_start, out_end);
    endproperty
    a_program_readout: assert property (p_program_readout)  // [RQ9]
        else $error("program readout not presented");

    property p_line_readout;
        $rose(line_number_readout_req) && !$rose(program_number_readout_req)
            |=> line_readout_active;
    endproperty
    a_line_readout: assert property (p_line_readout)  // [RQ10]
        else $error("line readout indicator missing");

    property p_override_readout;
        $rose(override_readout_req) && req_rise[1:0] == 2'h0 |=> override_readout_active;
    endproperty
    a_override_readout: assert property (p_override_readout)  // [RQ11]
        else $error("override readout indicator missing");

    property p_error_readout;
        $rose(error_number_readout_req) && req_rise[2:0] == 3'h0 |=> error_readout_active;
    endproperty
    a_error_readout: assert property (p_error_readout)  // [RQ12]
        else $error("error readout indicator missing");

    property p_one_readout;
        $onehot0({program_readout_active, line_readout_active,
                  override_readout_active, error_readout_active});
    endproperty
    a_one_readout: assert property (p_one_readout)  // [RQ20]
        else $error("more than one readout indicator high");

    property p_jog_enable;
        $rose(external_jog_enable) |=> jog_valid_out;
    endproperty
    a_jog_enable: assert property (p_jog_enable)  // [RQ13]
        else $error("jog valid not set on enable rise");

    property p_jog_hold;
        jog_valid_out && !(wr_acc && apb_req.paddr == rdio_pkg::OFS_CTRL) |=> jog_valid_out;
    endproperty
    a_jog_hold: assert property (p_jog_hold)  // [RQ2]
        else $error("jog valid dropped without a clear");

    property p_slot_wait;
        ##1 slot_wait_out == ($past(slot_pause_in) & $past(r.slot_run) & SLOT_MASK);
    endproperty
    a_slot_wait: assert property (p_slot_wait)  // [RQ4]
        else $error("slot wait does not follow pause input");

    property p_hand_fault;
        ##1 hand_fault_out == $past(hand_fault_signal);
    endproperty
    a_hand_fault: assert property (p_hand_fault)  // [RQ19]
        else $error("hand fault output does not follow input");

    c_program_select: cover property ($rose(program_select_in) ##1 r.program_number != 32'h0);
    c_readout_switch: cover property (line_readout_active ##[1:20] error_readout_active);
    c_jog_axis: cover property (jog_valid_out && axis_jog_pos != 8'h00);
endmodule // rdio_handler

`default_nettype wire

// ==== rdio_plc_model.sv ====
// Purpose: external sequencer model driving the dedicated input bits
// Assumes: all pins change by non-blocking assignment after a rising mclk edge
// Notes:   the numeric field is scrambled once a selection has consumed it
`timescale 1ns/1ps
`default_nettype none
module rdio_plc_model (
    input  wire logic        mclk,
    output logic             program_select_in,
    output logic             override_select_in,
    output logic [31:0]      numeric_value_field,
    output logic [3:0]       readout_req,
    output logic             external_jog_enable,
    output logic [1:0]       jog_mode_select,
    output logic [7:0]       jog_pos_req,
    output logic [7:0]       jog_neg_req,
    output logic [31:0]      slot_pause_in,
    output logic [23:0]      hand_input_pins,
    output logic [2:0]       hand_fault_signal
);
    initial begin
        {program_select_in, override_select_in, numeric_value_field, readout_req} = '0;
        {external_jog_enable, jog_mode_select, jog_pos_req, jog_neg_req} = '0;
        {slot_pause_in, hand_input_pins, hand_fault_signal} = '0;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic sel(input bit ovr, input logic [31:0] v);
        @(posedge mclk);
        numeric_value_field <= v;
        @(posedge mclk);
        if (ovr) override_select_in <= 1'b1; else program_select_in <= 1'b1;
        repeat (2) @(posedge mclk);
        override_select_in <= 1'b0;
        program_select_in <= 1'b0;
        @(posedge mclk);
        // stale field is not kept: inverted so a late capture shows up
        numeric_value_field <= ~v;
    endtask
    task automatic readout(input int k);
        @(posedge mclk);
        readout_req <= 4'b0001 << k;
        repeat (2) @(posedge mclk);
        readout_req <= 4'h0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic jog_on();
        @(posedge mclk);
        external_jog_enable <= 1'b1;
        @(posedge mclk);
        external_jog_enable <= 1'b0;
    endtask
    task automatic lv(input logic [31:0] p, input logic [1:0] m, input logic [7:0] jp,
                      input logic [7:0] jn, input logic [23:0] hi, input logic [2:0] hf);
        @(posedge mclk);
        slot_pause_in <= p;
        jog_mode_select <= m;
        jog_pos_req <= jp;
        jog_neg_req <= jn;
        hand_input_pins <= hi;
        hand_fault_signal <= hf;
    endtask
endmodule // rdio_plc_model
`default_nettype wire

// ==== rdio_handler_tb.sv ====
// Purpose: self-checking bench of the dedicated parallel i/o handler
// Assumes: zero wait apb slave, registered outputs settle within two cycles
// Notes:   every expectation goes through one note queue
`timescale 1ns/1ps
`default_nettype none
`define CMP(n, e, s) begin checked++; if ((e) !== (s)) begin fails++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
module rdio_handler_tb;
    typedef struct packed { logic [3:0] src; logic [32:0] val; } rdio_note_type;
    logic                       mclk, rst_n, look;
    rdio_pkg::rdio_apb_req_type req;
    rdio_pkg::rdio_apb_rsp_type rsp;
    wire logic [31:0] pause, swait, field, nout;
    wire logic [3:0]  rq;
    wire logic        psel_i, osel_i, jen, jvalid, ip, il, io, ie;
    wire logic [1:0]  jm, jmo;
    wire logic [7:0]  jp_i, jn_i, ap, an;
    wire logic [23:0] hos, hin, his;
    wire logic [2:0]  hf_i, hfo;
    wire logic [32:0] probe [0:8];
    rdio_note_type    notes [$];
    rdio_note_type    n;
    int               fails = 0, checked = 0;
    logic [31:0]      v, v2, v3, r, p, h, l, e;
    logic [7:0]       vals [4];
    string pname [0:8] = '{"nout", "wait", "ind", "jog", "axes", "hout", "hin", "hflt", "apb"};
    assign probe[0] = {1'b0, nout};
    assign probe[1] = {1'b0, swait};
    assign probe[2] = 33'({ie, io, il, ip});
    assign probe[3] = 33'({jmo, jvalid});
    assign probe[4] = 33'({an, ap});
    assign probe[5] = 33'(hos);
    assign probe[6] = 33'(his);
    assign probe[7] = 33'(hfo);
    assign probe[8] = {rsp.pslverr, rsp.prdata};
    rdio_handler u_dut (.mclk(mclk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
        .slot_pause_in(pause), .slot_wait_out(swait), .program_select_in(psel_i),
        .override_select_in(osel_i), .numeric_value_field(field), .numeric_value_out(nout),
        .program_number_readout_req(rq[0]), .line_number_readout_req(rq[1]),
        .override_readout_req(rq[2]), .error_number_readout_req(rq[3]),
        .program_readout_active(ip), .line_readout_active(il),
        .override_readout_active(io), .error_readout_active(ie),
        .external_jog_enable(jen), .jog_valid_out(jvalid), .jog_mode_select(jm),
        .jog_mode_out(jmo), .jog_pos_req(jp_i), .jog_neg_req(jn_i), .axis_jog_pos(ap),
        .axis_jog_neg(an), .hand_output_status_group(hos), .hand_input_pins(hin),
        .hand_input_status_group(his), .hand_fault_signal(hf_i), .hand_fault_out(hfo));
    rdio_plc_model u_plc (.mclk(mclk), .program_select_in(psel_i),
        .override_select_in(osel_i), .numeric_value_field(field), .readout_req(rq),
        .external_jog_enable(jen), .jog_mode_select(jm), .jog_pos_req(jp_i),
        .jog_neg_req(jn_i), .slot_pause_in(pause), .hand_input_pins(hin),
        .hand_fault_signal(hf_i));
    ////////////////////////////////////////////////////////////////////////////
    // checked at the falling edge so registered outputs have long settled
    always @(negedge mclk) begin
        if ((req.psel & req.penable & rsp.pready & ~req.pwrite) === 1'b1 || look) begin
            if (notes.size() == 0) `CMP("queue", 1'b1, 1'b0)
            else begin
                n = notes.pop_front();
                `CMP(pname[n.src], n.val, probe[n.src])
            end
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge mclk);
        req.penable <= 1'b1;
        // pready only counts on the rising edge that closes the access phase
        for (k = 0; k < 50; k++) begin
            @(posedge mclk);
            if (rsp.pready === 1'b1) break;
        end
        if (k == 50) begin fails++; stop_test(); end
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic err);
        notes.push_back({4'd8, err, x});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic see(input logic [3:0] s, input logic [32:0] x);
        notes.push_back({s, x});
        @(posedge mclk);
        look <= 1'b1;
        @(posedge mclk);
        look <= 1'b0;
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        req = '0;
        look = 1'b0;
        void'($urandom(58482));
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        rd(rdio_pkg::OFS_FIELD_CFG, 32'(rdio_pkg::RST_FIELD_CFG), 1'b0);
        rd(rdio_pkg::OFS_OVERRIDE, rdio_pkg::RST_OVERRIDE, 1'b0);
        apb(1'b1, rdio_pkg::OFS_PROGRAM, 32'h5a);
        rd(rdio_pkg::OFS_PROGRAM, 32'h0, 1'b0);
        rd(12'h03c, 32'h0, 1'b1);
        $display("test registers done");
        v = $urandom;
        v2 = $urandom;
        u_plc.sel(1'b0, v);
        rd(rdio_pkg::OFS_PROGRAM, {24'h0, v[7:0]}, 1'b0);
        u_plc.sel(1'b1, v2);
        rd(rdio_pkg::OFS_OVERRIDE, {24'h0, v2[7:0]}, 1'b0);
        $display("test select done");
        // in 4..11, out 8..15: moved fields catch a hard-wired bit range
        apb(1'b1, rdio_pkg::OFS_FIELD_CFG, {12'h0, 5'd15, 5'd8, 5'd11, 5'd4});
        v3 = $urandom;
        l = $urandom;
        e = $urandom;
        u_plc.sel(1'b0, v3);
        rd(rdio_pkg::OFS_PROGRAM, {24'h0, v3[11:4]}, 1'b0);
        apb(1'b1, rdio_pkg::OFS_LINE_NUM, l);
        apb(1'b1, rdio_pkg::OFS_ERROR_NUM, e);
        vals = '{v3[11:4], l[7:0], v2[7:0], e[7:0]};
        for (int k = 0; k < 4; k++) begin
            u_plc.readout(k);
            see(4'd2, 33'(4'b0001 << k));
            see(4'd0, {17'h0, vals[k], 8'h0});
        end
        $display("test readout done");
        r = $urandom;
        p = $urandom;
        h = $urandom;
        apb(1'b1, rdio_pkg::OFS_SLOT_RUN, r);
        apb(1'b1, rdio_pkg::OFS_HAND_OUT, h);
        u_plc.lv(p, 2'(v), v2[7:0], v2[15:8], l[23:0], e[10:8]);
        repeat (2) @(posedge mclk);
        see(4'd1, 33'(r & p));
        see(4'd3, 33'({v[1:0], 1'b0}));
        see(4'd4, 33'h0);
        see(4'd5, 33'(h[23:0]));
        see(4'd6, 33'(l[23:0]));
        see(4'd7, 33'(e[10:8]));
        u_plc.jog_on();
        repeat (3) @(posedge mclk);
        see(4'd3, 33'({v[1:0], 1'b1}));
        see(4'd4, 33'({v2[15:8], v2[7:0]}));
        apb(1'b1, rdio_pkg::OFS_CTRL, 32'h1);
        repeat (2) @(posedge mclk);
        see(4'd3, 33'({v[1:0], 1'b0}));
        rd(rdio_pkg::OFS_STATUS, {21'h0, e[10:8], 1'b0, 4'b1000, v[1:0], 1'b0}, 1'b0);
        u_plc.lv(32'h0, 2'h0, 8'h0, 8'h0, 24'h0, 3'h0);
        repeat (2) @(posedge mclk);
        see(4'd1, 33'h0);
        see(4'd6, 33'h0);
        see(4'd7, 33'h0);
        $display("test levels done");
        if (notes.size() != 0) fails++;
        stop_test();
    end
endmodule // rdio_handler_tb
`default_nettype wire
